// ==== hdl/adccfg_pkg.sv ====
package adccfg_pkg;
    localparam logic [7:0] PHASE_DELAY_OFFSET = 8'h45;
    localparam logic [7:0] FRONTEND_OFFSET = 8'h46;
    localparam logic [7:0] PHASE_DELAY_RESET = 8'h00;
    localparam logic [7:0] FRONTEND_RESET = 8'h10;
    localparam int KIND_BIT = 7;
    localparam int SOURCE_LSB = 5;
    localparam int COUPLING_BIT = 4;
    localparam int SWING_BIT = 3;
    localparam int AMP_LSB = 1;
    localparam int AUTOGAIN_BIT = 0;
    localparam int DELAY_DEPTH = 256;
    localparam logic [1:0] AMP_HIGH_SNR = 2'h0;
    localparam logic [1:0] AMP_FORBIDDEN = 2'h1;
    localparam logic [1:0] AMP_HIGH_CMRR = 2'h2;
    localparam logic [1:0] SOURCE_DIFF = 2'h0;
    localparam logic [1:0] SOURCE_SINGLE = 2'h1;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adccfg_req_t;

    typedef struct packed {
        logic thirdChannelInputKind;
        logic [1:0] thirdChannelSourceSelect;
        logic thirdChannelCouplingSelect;
        logic thirdChannelSwingRange;
        logic [1:0] thirdChannelAmpOptimisation;
        logic thirdChannelAutogainEnable;
    } adccfg_frontend_t;
endpackage : adccfg_pkg

// ==== hdl/adccfg_regs.sv ====
`timescale 1ns/1ps
module adccfg_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire adccfg_pkg::adccfg_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic modEn,
    input wire logic [15:0] secondChannelIn,
    output logic [15:0] secondChannelOut,
    output adccfg_pkg::adccfg_frontend_t frontend,
    output logic autogainActive
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] secondChannelPhaseDelay;
    logic [7:0] frontendCfg;
    logic [7:0] next_secondChannelPhaseDelay;
    logic [7:0] next_frontendCfg;
    logic [7:0] next_rdata;
    logic next_rvalid;

    always_comb begin
        next_secondChannelPhaseDelay = secondChannelPhaseDelay;
        next_frontendCfg = frontendCfg;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        if (req.write && req.addr == adccfg_pkg::PHASE_DELAY_OFFSET) begin
            next_secondChannelPhaseDelay = req.wdata;
        end
        if (req.write && req.addr == adccfg_pkg::FRONTEND_OFFSET) begin
            next_frontendCfg = req.wdata;
        end
        if (req.read) begin
            next_rvalid = 1'b1;
            unique case (req.addr)
                adccfg_pkg::PHASE_DELAY_OFFSET: next_rdata = secondChannelPhaseDelay;
                adccfg_pkg::FRONTEND_OFFSET: next_rdata = frontendCfg;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            secondChannelPhaseDelay <= adccfg_pkg::PHASE_DELAY_RESET;
            frontendCfg <= adccfg_pkg::FRONTEND_RESET;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else if (clkEn) begin
            secondChannelPhaseDelay <= next_secondChannelPhaseDelay;
            frontendCfg <= next_frontendCfg;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Front-end field decode
    adccfg_pkg::adccfg_frontend_t next_frontend;
    logic next_autogainActive;

    always_comb begin
        next_frontend.thirdChannelInputKind = frontendCfg[adccfg_pkg::KIND_BIT];
        next_frontend.thirdChannelSourceSelect =
            frontendCfg[adccfg_pkg::SOURCE_LSB +: 2];
        next_frontend.thirdChannelCouplingSelect = frontendCfg[adccfg_pkg::COUPLING_BIT];
        next_frontend.thirdChannelSwingRange = frontendCfg[adccfg_pkg::SWING_BIT];
        next_frontend.thirdChannelAmpOptimisation = frontendCfg[adccfg_pkg::AMP_LSB +: 2];
        next_frontend.thirdChannelAutogainEnable = frontendCfg[adccfg_pkg::AUTOGAIN_BIT];
        // Autogain runs only when enabled; active is the enable bit of the front-end register
        next_autogainActive = frontendCfg[adccfg_pkg::AUTOGAIN_BIT];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            frontend <= adccfg_pkg::adccfg_frontend_t'(adccfg_pkg::FRONTEND_RESET);
            autogainActive <= 1'b0;
        end else if (clkEn) begin
            frontend <= next_frontend;
            autogainActive <= next_autogainActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase-calibration delay line, one step per modulator strobe
    logic [15:0] delayMem [adccfg_pkg::DELAY_DEPTH];
    logic [7:0] wrPtr;
    logic [7:0] next_wrPtr;
    logic [7:0] rdPtr;
    logic [15:0] next_secondChannelOut;

    always_comb begin
        next_wrPtr = wrPtr;
        next_secondChannelOut = secondChannelOut;
        rdPtr = 8'(wrPtr - secondChannelPhaseDelay);
        if (modEn) begin
            next_wrPtr = 8'(wrPtr + 8'h01);
            if (secondChannelPhaseDelay == 8'h00) begin
                next_secondChannelOut = secondChannelIn;
            end else begin
                next_secondChannelOut = delayMem[rdPtr];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn && modEn) begin
            delayMem[wrPtr] <= secondChannelIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPtr <= 8'h00;
            secondChannelOut <= 16'h0000;
        end else if (clkEn) begin
            wrPtr <= next_wrPtr;
            secondChannelOut <= next_secondChannelOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Single register accesses on one enabled edge
    sequence s_front_write;
        clkEn && req.write && !req.read && req.addr == adccfg_pkg::FRONTEND_OFFSET;
    endsequence

    sequence s_front_read;
        clkEn && req.read && !req.write && req.addr == adccfg_pkg::FRONTEND_OFFSET;
    endsequence

    sequence s_phase_write;
        clkEn && req.write && !req.read && req.addr == adccfg_pkg::PHASE_DELAY_OFFSET;
    endsequence

    sequence s_phase_read;
        clkEn && req.read && !req.write && req.addr == adccfg_pkg::PHASE_DELAY_OFFSET;
    endsequence

    // Readback of a write read on the next edge, reset values, delay path and front-end field decode
    a_write_readback: assert property (@(posedge clk) disable iff (!nrst)
        s_front_write ##1 s_front_read |=> rvalid && rdata == $past(req.wdata, 2))
        else $error("Front-end register readback mismatch");
    a_phase_readback: assert property (@(posedge clk) disable iff (!nrst)
        s_phase_write ##1 s_phase_read |=> rvalid && rdata == $past(req.wdata, 2))
        else $error("Phase register readback mismatch");
    a_reset_coupling: assert property (@(posedge clk)
        !nrst |=> frontend.thirdChannelCouplingSelect && !frontend.thirdChannelInputKind)
        else $error("Front-end reset value wrong");
    a_reset_phase: assert property (@(posedge clk)
        !nrst |=> secondChannelPhaseDelay == 8'h00)
        else $error("Phase delay reset value wrong");
    a_zero_delay: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && modEn && secondChannelPhaseDelay == 8'h00
        |=> secondChannelOut == $past(secondChannelIn))
        else $error("Zero delay path not transparent");
    a_one_delay: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && modEn && secondChannelPhaseDelay == 8'h01 ##1
        clkEn && modEn && secondChannelPhaseDelay == 8'h01
        |=> secondChannelOut == $past(secondChannelIn, 2))
        else $error("One-cycle delay wrong");
    a_kind_field: assert property (@(posedge clk) disable iff (!nrst)
        clkEn ##1 clkEn |-> frontend.thirdChannelInputKind == $past(frontendCfg[7]))
        else $error("Input kind field wrong");
    a_source_swing: assert property (@(posedge clk) disable iff (!nrst)
        clkEn ##1 clkEn |-> frontend.thirdChannelSourceSelect == $past(frontendCfg[6:5])
        && frontend.thirdChannelSwingRange == $past(frontendCfg[3]))
        else $error("Source or swing field wrong");
    a_amp_field: assert property (@(posedge clk) disable iff (!nrst)
        clkEn ##1 clkEn |-> frontend.thirdChannelAmpOptimisation == $past(frontendCfg[2:1]))
        else $error("Amp field wrong");
    a_autogain_en: assert property (@(posedge clk) disable iff (!nrst)
        clkEn ##1 clkEn |-> autogainActive == $past(frontendCfg[0])
        && frontend.thirdChannelAutogainEnable == autogainActive)
        else $error("Autogain enable wrong");
    a_coupling_field: assert property (@(posedge clk) disable iff (!nrst)
        clkEn ##1 clkEn |-> frontend.thirdChannelCouplingSelect == $past(frontendCfg[4]))
        else $error("Coupling field wrong");

    // Bus answer and hold behaviour
    a_read_pulse: assert property (@(posedge clk) disable iff (!nrst)
        clkEn |=> rvalid == $past(req.read))
        else $error("Read valid pulse wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && req.read && req.addr != adccfg_pkg::PHASE_DELAY_OFFSET
        && req.addr != adccfg_pkg::FRONTEND_OFFSET |=> rdata == 8'h00)
        else $error("Unmapped read not zero");
    a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && !req.read |=> $stable(rdata))
        else $error("Read data moved without a read");
    a_phase_lands: assert property (@(posedge clk) disable iff (!nrst)
        s_phase_write |=> secondChannelPhaseDelay == $past(req.wdata))
        else $error("Phase write not stored");
    a_front_lands: assert property (@(posedge clk) disable iff (!nrst)
        s_front_write |=> frontendCfg == $past(req.wdata))
        else $error("Front-end write not stored");
    a_freeze_hold: assert property (@(posedge clk) disable iff (!nrst)
        !clkEn |=> $stable(secondChannelPhaseDelay) && $stable(frontendCfg)
        && $stable(secondChannelOut) && $stable(rvalid) && $stable(wrPtr))
        else $error("State moved while clock enable low");
    a_reset_values: assert property (@(posedge clk)
        !nrst |=> frontendCfg == adccfg_pkg::FRONTEND_RESET && rdata == 8'h00
        && !rvalid && !autogainActive && secondChannelOut == 16'h0000)
        else $error("Reset values wrong");

    // Delay line stepping
    a_ptr_step: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && modEn |=> wrPtr == 8'($past(wrPtr) + 8'h01))
        else $error("Delay pointer did not step");
    a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
        clkEn && !modEn |=> $stable(secondChannelOut) && $stable(wrPtr))
        else $error("Delay line moved without strobe");
endmodule : adccfg_regs

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, nrst = 0, clkEn = 1, modEn = 0, chkOn = 0, rvalid, autogainActive;
    adccfg_pkg::adccfg_req_t req = '0;
    adccfg_pkg::adccfg_frontend_t frontend;
    logic [7:0] rdata, d = 0, v, r;
    logic [7:0] dl [0:4] = '{8'h00, 8'h01, 8'h02, 8'hff, 8'h00};
    logic [15:0] secondChannelIn = '0, secondChannelOut, frozenOut;
    logic [15:0] hist [0:4095];
    logic [31:0] seed = 32'h690f7954;
    int err_count = 0, checks_done = 0, sc = 0, cyc = 0;
    adccfg_regs adccfg_regs_inst (.clk(clk), .nrst(nrst), .clkEn(clkEn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .modEn(modEn), .secondChannelIn(secondChannelIn),
        .secondChannelOut(secondChannelOut), .frontend(frontend), .autogainActive(autogainActive));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // Register access, read waits a bounded time for rvalid
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int i;
        @(posedge clk);
        req <= '{write: wr, read: !wr, addr: a, wdata: wd};
        @(posedge clk);
        req <= '0;
        if (!wr) begin
            i = 1;
            #1;
            while (rvalid !== 1'b1 && i < 4) begin
                @(posedge clk);
                #1;
                i++;
            end
            chk("read_latency", 1, i);
            r = rdata;
        end
    endtask : acc
    // Write, then read the same register on the next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: wd};
        @(posedge clk);
        req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        chk("wr_rd_valid", 1, rvalid);
        r = rdata;
    endtask : wr_rd
    task automatic rst_chk();
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("out_rst", 0, secondChannelOut);
        chk("rdata_rst", 0, rdata);
        chk("rvalid_rst", 0, rvalid);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("frontend_rst", 8'h10, frontend);
        chk("autogain_rst", 0, autogainActive);
        acc(0, 8'h45, 0);
        chk("phase_rst", 8'h00, r);
        acc(0, 8'h46, 0);
        chk("frontend_reg_rst", 8'h10, r);
    endtask : rst_chk
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        modEn <= (rnd() & 32'h3) != 0;
        secondChannelIn <= 16'(rnd() >> 16);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            $display("BAD timeout expected %0d seen %0d", 5000, cyc);
            end_sim();
        end else if (nrst && modEn && clkEn) begin
            hist[sc % 4096] = secondChannelIn;
            sc++;
            #1;
            if (chkOn && sc > 300) chk("delayed", hist[(sc - 1 - d) % 4096], secondChannelOut);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_chk();
        repeat (300) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            chkOn = 0;
            d = (k == 4) ? 8'(rnd() >> 24) : dl[k];
            wr_rd(8'h45, d);
            chk("phase_reg", d, r);
            chkOn = 1;
            repeat (300) @(posedge clk);
        end
        chkOn = 0;
        for (int k = 0; k < 16; k++) begin
            v = 8'(rnd() >> 24);
            v[2:1] = (k % 4 == 1) ? 2'h0 : 2'(k);
            v[6:5] = 2'(k >> 2);
            if (v[0]) begin
                v[4] = 1'b0;
            end
            wr_rd(8'h46, v);
            chk("frontend_reg", v, r);
            chk("frontend", v, frontend);
            chk("amp", v[adccfg_pkg::AMP_LSB +: 2], frontend.thirdChannelAmpOptimisation);
            chk("autogain", v[0], autogainActive);
        end
        // Clock enable low: a write is ignored and every output holds
        clkEn <= 1'b0;
        frozenOut = secondChannelOut;
        acc(1, 8'h45, ~d);
        repeat (3) @(posedge clk);
        #1;
        chk("frozen_out", frozenOut, secondChannelOut);
        chk("frozen_front", v, frontend);
        clkEn <= 1'b1;
        acc(0, 8'h45, 0);
        chk("phase_frozen", d, r);
        v = 8'(rnd() >> 24) | 8'h80;
        acc(1, v, 8'hff);
        acc(0, v, 0);
        chk("unmapped", 0, r);
        acc(0, 8'h45, 0);
        chk("phase_keep", d, r);
        rst_chk();
        end_sim();
    end
endmodule : tb_top
